/* include/usckg_pkg.sv */
// Shared types and constants for the serial transceiver clock generator.
// Assumes a single 50 MHz peripheral clock and a synchronous active-low reset.
package usckg_pkg;

    // Clock generation modes; async speed is chosen by double_speed_select.
    typedef enum logic [1:0] {
        USCKG_ASYNC,
        USCKG_SYNC_MASTER,
        USCKG_SYNC_SLAVE,
        USCKG_MASTER_SPI
    } usckg_mode_t;

    // Static configuration, driven by the host's control bits.
    typedef struct packed {
        usckg_mode_t mode;
        logic double_speed_select;
        logic [11:0] baud_period_setting;
        logic signed [3:0] baud_scale_exponent;
    } usckg_cfg_t;

    // Timing strobes handed to the transmitter and receiver.
    typedef struct packed {
        logic sample_tick;
        logic bit_tick;
        logic clk_rise;
        logic clk_fall;
    } usckg_tick_t;

    // Value the configuration register holds after reset.
    localparam usckg_cfg_t USCKG_CFG_RST = '{USCKG_ASYNC, 1'b0, 12'h000, 4'sh0};
    // Last oversample index at normal speed, 16 samples per bit.
    localparam logic [3:0] USCKG_LAST_NORMAL = 4'hF;
    // Last oversample index at double speed, 8 samples per bit.
    localparam logic [3:0] USCKG_LAST_DOUBLE = 4'h7;
    // Samples per bit reported to the receiver.
    localparam logic [4:0] USCKG_SPB_NORMAL = 5'h10;
    localparam logic [4:0] USCKG_SPB_DOUBLE = 5'h08;
    // Reset values of counters and strobes.
    localparam logic [11:0] USCKG_CNT_RST = 12'h000;
    localparam logic [6:0] USCKG_FRAC_RST = 7'h00;
    localparam logic [3:0] USCKG_SAMP_RST = 4'h0;
    localparam usckg_tick_t USCKG_TICK_RST = '{1'b0, 1'b0, 1'b0, 1'b0};

endpackage

/* rtl/usckg_pin_sync.sv */
// Two-stage synchroniser for the transfer clock pin.
// Assumes the pin is asynchronous to i_ref_clk; the first stage is read only by the second.
`timescale 1ns/100ps
module usckg_pin_sync (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Raw pin and its synchronised level.
    input wire logic i_pin,
    output logic o_level
);

    // First stage, may go metastable, feeds only the second stage.
    logic meta_q;

    // Both stages reset low so no false edge is seen after reset.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            meta_q <= 1'b0;
            o_level <= 1'b0;
        end else begin
            meta_q <= i_pin;
            o_level <= meta_q;
        end
    end

endmodule

/* rtl/usckg_clock_gen.sv */
// Clock generator of a serial transceiver: fractional baud generator and slave clock input.
// Assumes the configuration is static while a frame is on the line; a change restarts counts.
// Function
// - Five modes: async normal/double, sync master/slave, SPI.
// - Fractional generator clocks async, sync master, SPI.
// - Period setting is unsigned, 0 to 4095.
// - Scale exponent is signed, -7 to +7.
// - Normal async rate formulas, at most clock/16.
// - Double async uses divisor 8, at most clock/8.
// - Sync master and SPI: clock/(2(period+1)).
// - Sync slave takes bit clock from pin.
// - Pin sampled by clock; peer keeps it below clock/4.
// - SPI disables async logic, keeps buffers and generator.
// - Double speed receiver uses 8 samples per bit.
`timescale 1ns/100ps
module usckg_clock_gen (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Configuration bits.
    input wire usckg_pkg::usckg_cfg_t i_cfg,
    // Transfer clock pin, three-signal form.
    input wire logic i_transfer_clock_pin,
    output logic o_transfer_clock_pin,
    output logic o_transfer_clock_pin_oe,
    // Timing strobes and mode status.
    output usckg_pkg::usckg_tick_t o_tick,
    output logic [4:0] o_samples_per_bit,
    output logic o_async_logic_en,
    output logic o_shift_logic_en
);
    import usckg_pkg::*;

    // Magnitude of a signed exponent; -8 is outside the legal range and folds to 0.
    function automatic logic [2:0] exp_mag(input logic signed [3:0] e);
        logic [3:0] n;
        n = 4'(-e);
        exp_mag = e[3] ? n[2:0] : e[2:0];
    endfunction

    // True for the two modes that drive the pin from the generator.
    function automatic logic is_sync_gen(input usckg_mode_t m);
        is_sync_gen = (m == USCKG_SYNC_MASTER) || (m == USCKG_MASTER_SPI);
    endfunction

    usckg_cfg_t cfg_q; // Configuration in use by the counters.
    logic cfg_chg; // A rewrite of any configuration bit.
    logic gen_run; // Internal generator active.
    logic sync_gen; // Half-period generation for sync master and SPI.
    logic [2:0] mag; // Effective exponent magnitude.
    logic neg; // Effective exponent is negative.
    logic [7:0] mask8; // 2^mag - 1, widened.
    logic [6:0] mask7; // 2^mag - 1.
    logic [11:0] shifted; // Integer part of period/2^mag for negative exponents, else the period itself.
    logic [11:0] reload; // Terminal count of the current base period.
    logic base_tick; // Base counter expiry.
    logic [7:0] frac_sum; // Fraction accumulator plus this period's fraction.
    logic frac_carry; // Accumulated fraction reached one cycle.
    logic sample_tick_d; // Generator output strobe.
    logic [3:0] last_samp; // Last oversample index for this speed.
    logic pin_level; // Synchronised pin level.
    logic pin_prev_q; // Previous synchronised level for edge detection.
    logic [11:0] cnt_q; // Base counter.
    logic [6:0] pre_q; // Power-of-two prescaler for positive exponents.
    logic [6:0] acc_q; // Fraction accumulator for negative exponents.
    logic extra_q; // Stretch the current base period by one cycle.
    logic [3:0] samp_q; // Oversample index within a bit.
    logic gen_clk_q; // Generated transfer clock level.
    usckg_tick_t tick_d; // Next value of the strobe outputs.

    // Pin synchroniser; only its second stage is visible here.
    usckg_pin_sync u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_pin(i_transfer_clock_pin),
        .o_level(pin_level)
    );

    // Decode the effective division; sync modes ignore the exponent by design.
    always_comb begin
        cfg_chg = (i_cfg != cfg_q);
        gen_run = (cfg_q.mode != USCKG_SYNC_SLAVE);
        sync_gen = is_sync_gen(cfg_q.mode);
        mag = sync_gen ? 3'h0 : exp_mag(cfg_q.baud_scale_exponent);
        neg = !sync_gen && cfg_q.baud_scale_exponent[3];
        mask8 = (8'h01 << mag) - 8'h01;
        mask7 = mask8[6:0];
        shifted = neg ? (cfg_q.baud_period_setting >> mag) : cfg_q.baud_period_setting;
        reload = shifted + {11'h000, extra_q};
        base_tick = gen_run && (cnt_q == reload);
        frac_sum = {1'b0, acc_q} + {1'b0, cfg_q.baud_period_setting[6:0] & mask7};
        frac_carry = |(frac_sum >> mag);
        sample_tick_d = base_tick && (neg || (pre_q == mask7));
        last_samp = cfg_q.double_speed_select ? USCKG_LAST_DOUBLE : USCKG_LAST_NORMAL;
    end

    // Configuration is taken every cycle; a difference marks a rewrite.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            cfg_q <= USCKG_CFG_RST;
        end else begin
            cfg_q <= i_cfg;
        end
    end

    // Base counter counts up to the reload value, restarting on any rewrite.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || cfg_chg || !gen_run) begin
            cnt_q <= USCKG_CNT_RST;
        end else if (base_tick) begin
            cnt_q <= USCKG_CNT_RST;
        end else begin
            cnt_q <= cnt_q + 12'h001;
        end
    end

    // Fraction and prescale state; a negative exponent spreads the remainder
    // over periods, so single periods jitter by one cycle but the mean is exact.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || cfg_chg || !gen_run) begin
            pre_q <= USCKG_FRAC_RST;
            acc_q <= USCKG_FRAC_RST;
            extra_q <= 1'b0;
        end else if (base_tick) begin
            pre_q <= (pre_q == mask7) ? USCKG_FRAC_RST : pre_q + 7'h01;
            acc_q <= frac_sum[6:0] & mask7;
            extra_q <= neg && frac_carry;
        end
    end

    // Oversample index and generated clock level.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || cfg_chg) begin
            samp_q <= USCKG_SAMP_RST;
            gen_clk_q <= 1'b0;
        end else if (sample_tick_d) begin
            samp_q <= (samp_q == last_samp) ? USCKG_SAMP_RST : samp_q + 4'h1;
            gen_clk_q <= sync_gen ? !gen_clk_q : 1'b0;
        end
    end

    // Strobes: async bit at index wrap, sync master at falling half, slave at pin falling edges.
    always_comb begin
        tick_d = USCKG_TICK_RST;
        case (cfg_q.mode)
            USCKG_ASYNC: begin
                tick_d.sample_tick = sample_tick_d;
                tick_d.bit_tick = sample_tick_d && (samp_q == last_samp);
            end
            USCKG_SYNC_MASTER, USCKG_MASTER_SPI: begin
                tick_d.sample_tick = sample_tick_d;
                tick_d.bit_tick = sample_tick_d && gen_clk_q;
                tick_d.clk_rise = sample_tick_d && !gen_clk_q;
                tick_d.clk_fall = sample_tick_d && gen_clk_q;
            end
            USCKG_SYNC_SLAVE: begin
                tick_d.clk_rise = pin_level && !pin_prev_q;
                tick_d.clk_fall = !pin_level && pin_prev_q;
                tick_d.bit_tick = !pin_level && pin_prev_q;
            end
            default: begin
                tick_d = USCKG_TICK_RST;
            end
        endcase
    end

    // Registered strobes and the edge-detect history of the pin.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_tick <= USCKG_TICK_RST;
            pin_prev_q <= 1'b0;
        end else begin
            o_tick <= tick_d;
            pin_prev_q <= pin_level;
        end
    end

    // Pin drive and mode status; SPI only drops the async-only logic.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_transfer_clock_pin <= 1'b0;
            o_transfer_clock_pin_oe <= 1'b0;
            o_samples_per_bit <= USCKG_SPB_NORMAL;
            o_async_logic_en <= 1'b1;
            o_shift_logic_en <= 1'b1;
        end else begin
            o_transfer_clock_pin <= gen_clk_q;
            o_transfer_clock_pin_oe <= is_sync_gen(cfg_q.mode);
            o_samples_per_bit <= cfg_q.double_speed_select ? USCKG_SPB_DOUBLE
                                                           : USCKG_SPB_NORMAL;
            o_async_logic_en <= (cfg_q.mode == USCKG_ASYNC);
            o_shift_logic_en <= 1'b1;
        end
    end

    // Checking helpers: cycles since the last generator strobe.
    logic [19:0] gap_q;
    logic [19:0] pos_gap;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || cfg_chg || sample_tick_d) begin
            gap_q <= 20'h00000;
        end else begin
            gap_q <= gap_q + 20'h00001;
        end
    end
    assign pos_gap = (({8'h00, cfg_q.baud_period_setting} + 20'h00001) << mag) - 20'h00001;

    // One step of the async bit sequence: the wrap strobe then the registered bit.
    sequence s_wrap;
        sample_tick_d && (samp_q == last_samp) && (cfg_q.mode == USCKG_ASYNC) && !cfg_chg;
    endsequence
    sequence s_bit_out;
        o_tick.bit_tick && o_tick.sample_tick;
    endsequence
    sequence s_slave_fall;
        (cfg_q.mode == USCKG_SYNC_SLAVE) && !pin_level && pin_prev_q && !cfg_chg;
    endsequence

    AST_SYNC_PERIOD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        sample_tick_d && sync_gen |-> gap_q == {8'h00, cfg_q.baud_period_setting})
        else $error("Sync half period differs from period setting plus one.");
    AST_POS_SCALE_PERIOD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        sample_tick_d && !sync_gen && !neg |-> gap_q == pos_gap)
        else $error("Sample period differs from 2^exp times period plus one.");
    AST_NEG_SCALE_PERIOD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        sample_tick_d && neg |-> gap_q == {8'h00, shifted} || gap_q == {8'h00, shifted} + 20'h1)
        else $error("Fractional sample period outside its two integer neighbours.");
    AST_ASYNC_BIT: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        s_wrap |=> s_bit_out)
        else $error("Async bit strobe missing after last oversample.");
    AST_BIT_ONLY_AT_WRAP: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        o_tick.bit_tick && o_tick.sample_tick && $past(cfg_q.mode) == USCKG_ASYNC
        |-> $past(samp_q) == $past(last_samp))
        else $error("Async bit strobe at a wrong oversample index.");
    AST_SLAVE_EDGE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        s_slave_fall |=> o_tick.bit_tick && o_tick.clk_fall && !o_tick.sample_tick)
        else $error("Slave bit strobe not taken from the pin falling edge.");
    AST_SLAVE_NO_GEN: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        cfg_q.mode == USCKG_SYNC_SLAVE |-> !sample_tick_d ##1 !o_transfer_clock_pin_oe)
        else $error("Generator or pin driver active in sync slave mode.");
    AST_SPI_MODE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        cfg_q.mode == USCKG_MASTER_SPI && !cfg_chg
        |=> !o_async_logic_en && o_shift_logic_en && o_transfer_clock_pin_oe)
        else $error("SPI mode did not drop async logic while keeping the rest.");
    AST_RESTART: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        cfg_chg |=> cnt_q == USCKG_CNT_RST && samp_q == USCKG_SAMP_RST)
        else $error("Counters did not restart after a configuration rewrite.");
    AST_SPB: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        cfg_q.double_speed_select && !cfg_chg |=> o_samples_per_bit == USCKG_SPB_DOUBLE)
        else $error("Double speed does not report 8 samples per bit.");

endmodule

/* tb/usckg_peer_model.sv */
// Far-side serial peer that supplies the transfer clock in synchronous slave mode.
// Assumes it shares the bench's reference clock only to time its own phases.
`timescale 1ns/100ps
module usckg_peer_model (
    // Reference clock used to time the phases.
    input wire logic i_ref_clk,
    // Clock enable from the bench.
    input wire logic i_en,
    // Clock the peer drives towards the device.
    output logic o_pin
);
    // Phase length in reference cycles; three keeps the clock under a quarter rate.
    localparam int HALF = 3;
    // Cycle counter within the current phase.
    int cnt = 0;

    // The clock stands low outside frames and toggles every HALF cycles inside them.
    initial o_pin = 1'b0;
    always @(negedge i_ref_clk) begin
        if (!i_en) begin
            cnt <= 0;
            o_pin <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            o_pin <= ~o_pin;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the serial transceiver clock generator.
// Assumes the design registers its strobes; ticks are read at falling edges.
`timescale 1ns/100ps
module tb_top;
    import usckg_pkg::*;
    logic i_ref_clk = 1'b0; // Reference clock, 50 MHz.
    logic i_rst_b = 1'b0; // Synchronous reset, active low.
    usckg_cfg_t cfg = USCKG_CFG_RST; // Configuration bits driven by the bench.
    logic peer_en = 1'b0; // Lets the peer clock run.
    logic peer_pin; // Peer's clock output.
    logic dev_pin, dev_oe, pin_wire, async_en, shift_en; // Pin and status wires.
    usckg_tick_t tick; // Timing strobes.
    logic [4:0] spb; // Samples per bit.
    int fail_count = 0; // Mismatches seen.
    int cmp_count = 0; // Comparisons made.

    // The wire follows whichever party drives it.
    assign pin_wire = dev_oe ? dev_pin : peer_pin;
    always #10 i_ref_clk = ~i_ref_clk;

    usckg_clock_gen u_usckg_clock_gen (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_cfg(cfg),
        .i_transfer_clock_pin(pin_wire), .o_transfer_clock_pin(dev_pin),
        .o_transfer_clock_pin_oe(dev_oe), .o_tick(tick), .o_samples_per_bit(spb),
        .o_async_logic_en(async_en), .o_shift_logic_en(shift_en));
    usckg_peer_model u_usckg_peer_model (.i_ref_clk(i_ref_clk), .i_en(peer_en), .o_pin(peer_pin));

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // Counts cycles between two bit ticks; a bounded wait keeps a dead design from hanging.
    task automatic gap(output logic [31:0] n);
        int k;
        k = 0;
        while (tick.bit_tick !== 1'b1 && k < 20000) begin
            @(negedge i_ref_clk);
            k++;
        end
        @(negedge i_ref_clk);
        n = 1;
        while (tick.bit_tick !== 1'b1 && n < 20000) begin
            @(negedge i_ref_clk);
            n++;
        end
    endtask

    // Applies a setting, lets the restart settle, then checks one bit interval.
    task automatic run(input usckg_mode_t m, input logic d, input logic [11:0] p,
                       input logic [3:0] x, input logic [31:0] e);
        logic [31:0] n;
        @(negedge i_ref_clk);
        cfg <= '{m, d, p, x};
        repeat (40) @(negedge i_ref_clk);
        gap(n);
        chk("bit interval", e, n);
    endtask

    // Reset values at the ports.
    task automatic t_reset();
        chk("oe", 0, dev_oe);
        chk("ticks", 0, tick);
        chk("spb", 16, spb);
        chk("async en", 1, async_en);
        chk("shift en", 1, shift_en);
    endtask

    // Normal-speed asynchronous rates, positive and negative exponents.
    task automatic t_async_normal();
        run(USCKG_ASYNC, 1'b0, 12'h000, 4'h0, 16);
        chk("sample tick", 1, tick.sample_tick);
        run(USCKG_ASYNC, 1'b0, 12'h003, 4'h0, 64);
        run(USCKG_ASYNC, 1'b0, 12'h001, 4'h2, 128);
        run(USCKG_ASYNC, 1'b0, 12'h002, 4'hF, 32);
        chk("spb", 16, spb);
        chk("async en", 1, async_en);
        chk("oe", 0, dev_oe);
    endtask

    // Double-speed asynchronous rates and sample count.
    task automatic t_async_double();
        run(USCKG_ASYNC, 1'b1, 12'h000, 4'h0, 8);
        run(USCKG_ASYNC, 1'b1, 12'h001, 4'h1, 32);
        chk("spb", 8, spb);
    endtask

    // Synchronous master: exponent ignored, periods 1 and 4095.
    task automatic t_sync_master();
        int k;
        run(USCKG_SYNC_MASTER, 1'b0, 12'h001, 4'h3, 4);
        chk("oe", 1, dev_oe);
        k = 0;
        while (tick.clk_rise !== 1'b1 && k < 10) begin
            @(negedge i_ref_clk);
            k++;
        end
        chk("rise seen", 1, tick.clk_rise);
        // The pin is registered once more, so it rises one cycle after the strobe.
        @(negedge i_ref_clk);
        chk("pin high", 1, dev_pin);
        @(negedge i_ref_clk);
        chk("fall seen", 1, tick.clk_fall);
        run(USCKG_SYNC_MASTER, 1'b0, 12'hFFF, 4'h0, 8192);
    endtask

    // Master SPI keeps the generator but drops asynchronous logic.
    task automatic t_spi();
        run(USCKG_MASTER_SPI, 1'b0, 12'h004, 4'h0, 10);
        chk("async en", 0, async_en);
        chk("shift en", 1, shift_en);
        chk("oe", 1, dev_oe);
    endtask

    // Synchronous slave follows the peer's clock at six cycles a bit.
    task automatic t_slave();
        int k;
        peer_en <= 1'b1;
        run(USCKG_SYNC_SLAVE, 1'b0, 12'h000, 4'h0, 6);
        chk("oe", 0, dev_oe);
        chk("sample tick", 0, tick.sample_tick);
        k = 0;
        while (tick.clk_rise !== 1'b1 && k < 10) begin
            @(negedge i_ref_clk);
            k++;
        end
        chk("slave rise", 1, tick.clk_rise);
        @(negedge i_ref_clk);
        peer_en <= 1'b0;
    endtask

    // Prints the verdict and ends the run.
    task automatic results();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence; reset is checked while still held.
    initial begin
        repeat (4) @(negedge i_ref_clk);
        t_reset();
        i_rst_b = 1'b1;
        t_async_normal();
        t_async_double();
        t_sync_master();
        t_spi();
        t_slave();
        results();
    end

    // Watchdog sized well beyond the expected run of about 17000 cycles.
    initial begin
        #1000000;
        fail_count++;
        results();
    end
endmodule
